// file: logic/memory_space_pkg.sv
// Shared constants, modes and carriers for the memory space decode block
package memory_space_pkg;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned PROG_W        = 24;
   localparam int unsigned PSV_BIT       = 15;
   localparam int unsigned RAM_BYTES_DEF = 16384;
   localparam int unsigned NEAR_FIELD_W  = 13;
   localparam int unsigned SPACE_BYTES   = 32768;

   localparam logic [23:0] RESET_PC          = 24'h000000;
   localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
   localparam logic [23:0] PC_STEP           = 24'h000002;
   localparam logic [23:0] UPPER_WORD_OFS    = 24'h000001;
   localparam logic [23:0] VECTOR_AREA_END   = 24'h000200;
   localparam logic [23:0] PRI_VEC_BASE      = 24'h000004;
   localparam logic [23:0] ALT_VEC_OFFSET    = 24'h000100;
   localparam logic [6:0]  VEC_COUNT         = 7'h7e;

   localparam logic [15:0] SFR_LAST  = 16'h07ff;
   localparam logic [15:0] RAM_BASE  = 16'h0800;
   localparam logic [15:0] NEAR_LAST = 16'h1fff;
   localparam logic [15:0] BYTE_STEP = 16'h0001;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [1:0]  LANE_LO   = 2'h1;
   localparam logic [1:0]  LANE_HI   = 2'h2;
   localparam logic [1:0]  LANE_BOTH = 2'h3;
   localparam logic [1:0]  LANE_NONE = 2'h0;

   typedef enum logic [1:0] {AM_INDIRECT, AM_DIRECT16, AM_NEAR13} addr_mode_t;
   typedef enum logic [1:0] {
      REG_WORD, REG_BYTE_LOAD, REG_SIGN_EXT, REG_ZERO_EXT
   } wreg_op_t;
   typedef enum logic [1:0] {RGN_SFR, RGN_RAM, RGN_UNIMPL, RGN_PSV} region_t;

   typedef struct packed {
      addr_mode_t  mode;
      logic [15:0] pointer;
      logic [15:0] field;
      logic        byte_op;
      logic        post_inc;
   } agu_req_t;
endpackage

// file: logic/address_generator.sv
// Effective address and pointer update for one data access path
`timescale 1ns/1ps
module address_generator
   import memory_space_pkg::*;
(
   input  memory_space_pkg::agu_req_t req,
   output logic [15:0]                ea,
   output logic [15:0]                ptr_next
);
   logic [15:0] step;

   always_comb
   begin
      case (req.mode)
         AM_INDIRECT: ea = req.pointer;
         AM_DIRECT16: ea = req.field;
         AM_NEAR13:   ea = {3'h0, req.field[NEAR_FIELD_W-1:0]};
         default:     ea = req.pointer;
      endcase
   end

   // Byte steps keep odd pointers usable; word steps keep alignment
   assign step     = req.byte_op ? BYTE_STEP : WORD_STEP;
   assign ptr_next = req.post_inc ? req.pointer + step : req.pointer;
endmodule // address_generator

// file: logic/data_ram.sv
// Word RAM built as two byte lanes with shared decode
`timescale 1ns/1ps
module data_ram #(
   parameter int unsigned WORDS = 8192,
   parameter int unsigned AW    = 13
) (
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic [AW-1:0] rd_index,
   input  wire logic [AW-1:0] wr_index,
   input  wire logic [1:0]    wr_lane,
   input  wire logic [15:0]   wr_data,
   output logic [15:0]        q
);
   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_lane
         logic [7:0] mem [WORDS];
         // One shared index, one write line per lane
         always_ff @(posedge clk_sys)
         begin
            if (wr_lane[i])
               mem[wr_index] <= wr_data[8*i +: 8];
         end
         always_ff @(posedge clk_sys or posedge rst)
         begin
            if (rst)
               q[8*i +: 8] <= 8'h00;
            else
               q[8*i +: 8] <= mem[rd_index];
         end
      end
   endgenerate
endmodule // data_ram

// file: logic/memory_space_address_decode.sv
// Program counter, vector and data space decode with byte lane steering
`timescale 1ns/1ps
module memory_space_address_decode #(
   parameter int unsigned RAM_BYTES = memory_space_pkg::RAM_BYTES_DEF
) (
   input  wire logic                       clk_sys,
   input  wire logic                       rst,
   input  wire logic                       pc_inc,
   input  wire logic                       pc_dec,
   input  wire logic                       pc_load,
   input  wire logic [23:0]                pc_target,
   input  wire logic                       vec_take,
   input  wire logic                       vec_alt,
   input  wire logic [6:0]                 vec_num,
   input  wire logic                       prog_word_valid,
   input  wire logic [23:0]                prog_word,
   output logic [23:0]                     pc,
   output logic [23:0]                     pc_upper_addr,
   output logic [23:0]                     vec_fetch_addr,
   output logic                            vec_fetch_valid,
   output logic                            vector_area_load,
   output logic [15:0]                     prog_lower,
   output logic [15:0]                     prog_upper,
   output logic                            prog_valid,
   input  wire logic                       rd_req,
   input  wire memory_space_pkg::agu_req_t rd_agu,
   output logic [15:0]                     rd_ptr_next,
   output logic                            rd_ptr_valid,
   output logic [15:0]                     rd_data,
   output logic                            rd_valid,
   output logic                            sfr_rd_req,
   output logic [15:0]                     sfr_rd_addr,
   input  wire logic [15:0]                sfr_rd_data,
   input  wire logic                       sfr_rd_hit,
   output logic                            psv_rd_req,
   output logic [14:0]                     psv_rd_addr,
   input  wire logic [15:0]                psv_rd_data,
   input  wire logic                       wr_req,
   input  wire memory_space_pkg::agu_req_t wr_agu,
   input  wire logic [15:0]                wr_data,
   output logic [15:0]                     wr_ptr_next,
   output logic                            wr_ptr_valid,
   output logic                            sfr_wr_en,
   output logic [15:0]                     sfr_wr_addr,
   output logic [15:0]                     sfr_wr_data,
   output logic [1:0]                      sfr_wr_lane,
   input  wire logic                       reg_op_valid,
   input  wire memory_space_pkg::wreg_op_t reg_op,
   input  wire logic [15:0]                reg_old,
   input  wire logic [15:0]                reg_src,
   output logic [15:0]                     reg_result,
   output logic                            reg_result_valid,
   output logic                            addr_trap,
   output logic                            addr_trap_write
);
   import memory_space_pkg::*;
   localparam int unsigned RAM_WORDS = RAM_BYTES / 2;
   localparam int unsigned AW        = $clog2(RAM_WORDS);
   localparam logic [16:0] RAM_END   = 17'(RAM_BASE) + 17'(RAM_BYTES);

   // Below four bytes the word index would have no bits
   if (RAM_BYTES < 4 || RAM_BYTES % 2 != 0 ||
       int'(RAM_BASE) + RAM_BYTES > SPACE_BYTES)
   begin : g_bad_ram
      $error("RAM_BYTES must be even, at least 4 and fit below the window");
   end

   function automatic region_t decode_region(input logic [15:0] ea);
      if (ea[PSV_BIT])
         decode_region = RGN_PSV;
      else if (ea <= SFR_LAST)
         decode_region = RGN_SFR;
      else if ({1'b0, ea} < RAM_END)
         decode_region = RGN_RAM;
      else
         decode_region = RGN_UNIMPL;
   endfunction

   logic [23:0]    next_pc, vec_base;
   logic [15:0]    rd_ea, wr_ea, rd_ptr_nx, wr_ptr_nx, rd_ofs, wr_ofs;
   region_t        rd_rgn, wr_rgn, s1_rgn;
   logic           rd_mis, wr_mis, s1_valid, s1_byte, s1_odd;
   logic           s1_rd_mis, s1_wr_mis;
   logic [1:0]     wr_lanes, ram_wr_lane;
   logic [15:0]    wr_word, ram_q, s1_word, next_rd_data, next_reg;

   // Load beats stepping; clearing bit 0 keeps pc even
   assign next_pc = pc_load ? {pc_target[23:1], 1'b0}
                  : pc_inc  ? pc + PC_STEP
                  : pc_dec  ? pc - PC_STEP : pc;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pc            <= RESET_PC;
         pc_upper_addr <= RESET_PC + UPPER_WORD_OFS;
      end
      else
      begin
         pc            <= next_pc;
         pc_upper_addr <= next_pc + UPPER_WORD_OFS;
      end
   end

   // User code must live at or above the vector area
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         vector_area_load <= 1'b0;
      else
         vector_area_load <= pc_load &&
                             (pc_target < VECTOR_AREA_END);
   end

   assign vec_base = vec_alt ? PRI_VEC_BASE + ALT_VEC_OFFSET
                             : PRI_VEC_BASE;

   // Out of range vector numbers are dropped rather than aliased
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         vec_fetch_addr  <= RESET_TARGET_ADDR;
         vec_fetch_valid <= 1'b0;
      end
      else
      begin
         vec_fetch_valid <= vec_take && (vec_num < VEC_COUNT);
         if (vec_take && (vec_num < VEC_COUNT))
            vec_fetch_addr <= vec_base +
                              {16'h0000, vec_num, 1'b0};
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         prog_lower <= ZERO_WORD;
         prog_upper <= ZERO_WORD;
         prog_valid <= 1'b0;
      end
      else
      begin
         prog_valid <= prog_word_valid;
         if (prog_word_valid)
         begin
            prog_lower <= prog_word[15:0];
            prog_upper <= {ZERO_BYTE, prog_word[23:16]};
         end
      end
   end

   // Data side: one generator per direction
   address_generator u_rd_agu (
      .req      (rd_agu),
      .ea       (rd_ea),
      .ptr_next (rd_ptr_nx)
   );

   address_generator u_wr_agu (
      .req      (wr_agu),
      .ea       (wr_ea),
      .ptr_next (wr_ptr_nx)
   );

   assign rd_rgn = decode_region(rd_ea);
   assign wr_rgn = decode_region(wr_ea);
   assign rd_mis = rd_req && !rd_agu.byte_op && rd_ea[0];
   assign wr_mis = wr_req && !wr_agu.byte_op && wr_ea[0];
   assign rd_ofs = rd_ea - RAM_BASE;
   assign wr_ofs = wr_ea - RAM_BASE;

   assign wr_lanes = wr_mis          ? LANE_NONE
                   : !wr_agu.byte_op ? LANE_BOTH
                   : wr_ea[0]        ? LANE_HI : LANE_LO;

   assign wr_word     = wr_agu.byte_op ? {wr_data[7:0], wr_data[7:0]}
                                       : wr_data;
   assign ram_wr_lane = (wr_req && wr_rgn == RGN_RAM) ? wr_lanes
                                                       : LANE_NONE;

   data_ram #(
      .WORDS (RAM_WORDS),
      .AW    (AW)
   ) u_ram (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .rd_index (rd_ofs[AW:1]),
      .wr_index (wr_ofs[AW:1]),
      .wr_lane  (ram_wr_lane),
      .wr_data  (wr_word),
      .q        (ram_q)
   );

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rd_ptr_next  <= ZERO_WORD;
         rd_ptr_valid <= 1'b0;
         wr_ptr_next  <= ZERO_WORD;
         wr_ptr_valid <= 1'b0;
      end
      else
      begin
         rd_ptr_valid <= rd_req && rd_agu.post_inc;
         wr_ptr_valid <= wr_req && wr_agu.post_inc;
         if (rd_req)
            rd_ptr_next <= rd_ptr_nx;
         if (wr_req)
            wr_ptr_next <= wr_ptr_nx;
      end
   end

   // Read stage one: side requests and context for lane steering
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s1_valid    <= 1'b0;
         s1_rgn      <= RGN_UNIMPL;
         s1_byte     <= 1'b0;
         s1_odd      <= 1'b0;
         s1_rd_mis   <= 1'b0;
         s1_wr_mis   <= 1'b0;
         sfr_rd_req  <= 1'b0;
         sfr_rd_addr <= ZERO_WORD;
         psv_rd_req  <= 1'b0;
         psv_rd_addr <= 15'h0000;
      end
      else
      begin
         s1_valid    <= rd_req;
         s1_rgn      <= rd_rgn;
         s1_byte     <= rd_agu.byte_op;
         s1_odd      <= rd_ea[0];
         s1_rd_mis   <= rd_mis;
         s1_wr_mis   <= wr_mis;
         // Whole word is fetched; the byte is picked afterwards
         sfr_rd_req  <= rd_req && !rd_mis && rd_rgn == RGN_SFR;
         sfr_rd_addr <= {rd_ea[15:1], 1'b0};
         psv_rd_req  <= rd_req && !rd_mis && rd_rgn == RGN_PSV;
         psv_rd_addr <= {rd_ea[14:1], 1'b0};
      end
   end

   always_comb
   begin
      case (s1_rgn)
         RGN_SFR:    s1_word = sfr_rd_hit ? sfr_rd_data
                                          : ZERO_WORD;
         RGN_RAM:    s1_word = ram_q;
         RGN_PSV:    s1_word = psv_rd_data;
         RGN_UNIMPL: s1_word = ZERO_WORD;
         default:    s1_word = ZERO_WORD;
      endcase
   end

   assign next_rd_data = s1_rd_mis ? ZERO_WORD
                       : !s1_byte  ? s1_word
                       : s1_odd    ? {ZERO_BYTE, s1_word[15:8]}
                       : {ZERO_BYTE, s1_word[7:0]};

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rd_data  <= ZERO_WORD;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= s1_valid;
         if (s1_valid)
            rd_data <= next_rd_data;
      end
   end

   // Misaligned writes never reach the SFR bus
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         sfr_wr_en   <= 1'b0;
         sfr_wr_addr <= ZERO_WORD;
         sfr_wr_data <= ZERO_WORD;
         sfr_wr_lane <= LANE_NONE;
      end
      else
      begin
         sfr_wr_en   <= wr_req && !wr_mis && wr_rgn == RGN_SFR;
         sfr_wr_addr <= {wr_ea[15:1], 1'b0};
         sfr_wr_data <= wr_word;
         sfr_wr_lane <= wr_lanes;
      end
   end

   // Both traps leave together so a read and write clash is one pulse
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         addr_trap       <= 1'b0;
         addr_trap_write <= 1'b0;
      end
      else
      begin
         addr_trap       <= s1_rd_mis || s1_wr_mis;
         addr_trap_write <= s1_wr_mis;
      end
   end

   // Working register byte load and extension
   always_comb
   begin
      case (reg_op)
         REG_WORD:      next_reg = reg_src;
         REG_BYTE_LOAD: next_reg = {reg_old[15:8], reg_src[7:0]};
         REG_SIGN_EXT:  next_reg = {{8{reg_src[7]}}, reg_src[7:0]};
         REG_ZERO_EXT:  next_reg = {ZERO_BYTE, reg_src[7:0]};
         default:       next_reg = reg_old;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         reg_result       <= ZERO_WORD;
         reg_result_valid <= 1'b0;
      end
      else
      begin
         reg_result_valid <= reg_op_valid;
         if (reg_op_valid)
            reg_result <= next_reg;
      end
   end
endmodule // memory_space_address_decode

// file: tb/memory_space_checker_assertions.sv
// Temporal checks on the memory space decode block ports
`timescale 1ns/1ps
module memory_space_checker
   import memory_space_pkg::*;
#(
   parameter int unsigned RAM_BYTES = RAM_BYTES_DEF
) (
   input wire logic                       clk_sys,
   input wire logic                       rst,
   input wire logic                       pc_inc,
   input wire logic                       pc_load,
   input wire logic [23:0]                pc,
   input wire logic [23:0]                pc_upper_addr,
   input wire logic                       rd_req,
   input wire memory_space_pkg::agu_req_t rd_agu,
   input wire logic [15:0]                rd_ptr_next,
   input wire logic                       rd_ptr_valid,
   input wire logic [15:0]                rd_data,
   input wire logic                       rd_valid,
   input wire logic                       wr_req,
   input wire memory_space_pkg::agu_req_t wr_agu,
   input wire logic                       sfr_wr_en,
   input wire logic [1:0]                 sfr_wr_lane,
   input wire logic                       reg_op_valid,
   input wire memory_space_pkg::wreg_op_t reg_op,
   input wire logic [15:0]                reg_old,
   input wire logic [15:0]                reg_src,
   input wire logic [15:0]                reg_result,
   input wire logic                       addr_trap,
   input wire logic                       addr_trap_write
);
   logic        byte_q1;
   logic        byte_q2;
   logic        wr_odd_q;
   logic [15:0] ptr_exp;
   logic [15:0] reg_exp;

   // Expectations held one cycle, the read byte flag two, so results can be tied to their cause
   always_ff @(posedge clk_sys)
   begin
      byte_q1  <= rd_agu.byte_op;
      byte_q2  <= byte_q1;
      wr_odd_q <= wr_agu.pointer[0];
      ptr_exp  <= rd_agu.pointer + (rd_agu.byte_op ? BYTE_STEP : WORD_STEP);
      case (reg_op)
         REG_WORD:      reg_exp <= reg_src;
         REG_BYTE_LOAD: reg_exp <= {reg_old[15:8], reg_src[7:0]};
         REG_SIGN_EXT:  reg_exp <= {{8{reg_src[7]}}, reg_src[7:0]};
         default:       reg_exp <= {8'h00, reg_src[7:0]};
      endcase
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_rd_odd_word;
      rd_req && !rd_agu.byte_op && rd_agu.mode == AM_INDIRECT
         && rd_agu.pointer[0];
   endsequence
   sequence s_wr_odd_word;
      wr_req && !wr_agu.byte_op && wr_agu.mode == AM_INDIRECT
         && wr_agu.pointer[0];
   endsequence
   sequence s_trap_kind(logic w);
      addr_trap && addr_trap_write == w;
   endsequence

   property p_pc_step;
      pc_inc && !pc_load |=> pc == $past(pc) + PC_STEP;
   endproperty
   property p_pc_pair;
      pc[0] == 1'b0 && pc_upper_addr == pc + UPPER_WORD_OFS;
   endproperty
   property p_rd_latency;
      rd_req |-> ##2 rd_valid;
   endproperty
   property p_rd_odd;
      s_rd_odd_word |-> ##2 rd_valid && rd_data == ZERO_WORD
         ##0 s_trap_kind(1'b0);
   endproperty
   property p_wr_odd;
      s_wr_odd_word |=> !sfr_wr_en ##1 s_trap_kind(1'b1);
   endproperty
   property p_rd_byte;
      rd_valid && byte_q2 |-> rd_data[15:8] == 8'h00;
   endproperty
   property p_ptr_inc;
      rd_req && rd_agu.post_inc |=> rd_ptr_valid && rd_ptr_next == ptr_exp;
   endproperty
   property p_wr_lane;
      wr_req && wr_agu.byte_op && wr_agu.mode == AM_INDIRECT
         && wr_agu.pointer <= SFR_LAST
         |=> sfr_wr_en && sfr_wr_lane == (wr_odd_q ? LANE_HI : LANE_LO);
   endproperty
   property p_reg_op;
      reg_op_valid |=> reg_result == reg_exp;
   endproperty

   a_pc_step: assert property (p_pc_step)
      else $error("pc did not step by two");
   a_pc_pair: assert property (p_pc_pair)
      else $error("pc pair not even/odd");
   a_rd_latency: assert property (p_rd_latency)
      else $error("read answer missing");
   a_rd_odd: assert property (p_rd_odd)
      else $error("odd word read not trapped");
   a_wr_odd: assert property (p_wr_odd)
      else $error("odd word write not suppressed");
   a_rd_byte: assert property (p_rd_byte)
      else $error("byte read upper lane not zero");
   a_ptr_inc: assert property (p_ptr_inc)
      else $error("pointer step wrong");
   a_wr_lane: assert property (p_wr_lane)
      else $error("byte write lane wrong");
   a_reg_op: assert property (p_reg_op)
      else $error("register op result wrong");
endmodule // memory_space_checker

bind memory_space_address_decode memory_space_checker
   #(.RAM_BYTES(RAM_BYTES)) i_chk (.clk_sys, .rst, .pc_inc, .pc_load, .pc,
   .pc_upper_addr, .rd_req, .rd_agu, .rd_ptr_next, .rd_ptr_valid, .rd_data,
   .rd_valid, .wr_req, .wr_agu, .sfr_wr_en, .sfr_wr_lane, .reg_op_valid,
   .reg_op, .reg_old, .reg_src, .reg_result, .addr_trap, .addr_trap_write);

// file: tb/core_side_model.sv
// Far-side model: special function registers and visibility window
`timescale 1ns/1ps
module core_side_model (
   input  wire logic        clk_sys,
   input  wire logic        sfr_rd_req,
   input  wire logic [15:0] sfr_rd_addr,
   output logic [15:0]      sfr_rd_data,
   output logic             sfr_rd_hit,
   input  wire logic        psv_rd_req,
   input  wire logic [14:0] psv_rd_addr,
   output logic [15:0]      psv_rd_data,
   input  wire logic        sfr_wr_en,
   input  wire logic [15:0] sfr_wr_addr,
   input  wire logic [15:0] sfr_wr_data,
   input  wire logic [1:0]  sfr_wr_lane
);
   // Only 0x0000..0x00ff is backed; misses answer with junk on purpose
   logic [15:0] regs [128];

   always @(posedge clk_sys)
   begin
      if (sfr_wr_en && sfr_wr_addr < 16'h0100)
      begin
         if (sfr_wr_lane[0])
            regs[sfr_wr_addr[7:1]][7:0] <= sfr_wr_data[7:0];
         if (sfr_wr_lane[1])
            regs[sfr_wr_addr[7:1]][15:8] <= sfr_wr_data[15:8];
      end
   end

   always_comb
   begin
      sfr_rd_hit  = sfr_rd_req && sfr_rd_addr < 16'h0100;
      sfr_rd_data = sfr_rd_hit ? regs[sfr_rd_addr[7:1]] : ~sfr_rd_addr;
      psv_rd_data = {1'b0, psv_rd_addr} ^ (psv_rd_req ? 16'h5a5a : 16'ha5a5);
   end
endmodule // core_side_model

// file: tb/tb.sv
// Self-checking bench for the memory space decode block
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, 24'(e), 24'(g))
module tb;
   import memory_space_pkg::*;
   logic        clk_sys, rst, pc_inc, pc_dec, pc_load, vec_take, vec_alt;
   logic        prog_word_valid, rd_req, wr_req, reg_op_valid, rd_valid;
   logic        rd_ptr_valid, sfr_rd_req, sfr_rd_hit, psv_rd_req, sfr_wr_en;
   logic        wr_ptr_valid, vec_fetch_valid, vector_area_load, prog_valid;
   logic        reg_result_valid, addr_trap, addr_trap_write;
   logic [6:0]  vec_num;
   logic [1:0]  sfr_wr_lane;
   logic [14:0] psv_rd_addr;
   logic [23:0] pc_target, prog_word, pc, pc_upper_addr, vec_fetch_addr;
   logic [15:0] prog_lower, prog_upper, rd_ptr_next, rd_data, sfr_rd_addr;
   logic [15:0] sfr_rd_data, psv_rd_data, wr_data, wr_ptr_next, ptr_seen;
   logic [15:0] sfr_wr_addr, sfr_wr_data, reg_old, reg_src, reg_result;
   agu_req_t    rd_agu, wr_agu;
   wreg_op_t    reg_op;
   int          fail_count, check_count, cycles;

   memory_space_address_decode i_dut (.clk_sys, .rst, .pc_inc, .pc_dec,
      .pc_load, .pc_target, .vec_take, .vec_alt, .vec_num, .prog_word_valid,
      .prog_word, .pc, .pc_upper_addr, .vec_fetch_addr, .vec_fetch_valid,
      .vector_area_load, .prog_lower, .prog_upper, .prog_valid, .rd_req,
      .rd_agu, .rd_ptr_next, .rd_ptr_valid, .rd_data, .rd_valid, .sfr_rd_req,
      .sfr_rd_addr, .sfr_rd_data, .sfr_rd_hit, .psv_rd_req, .psv_rd_addr,
      .psv_rd_data, .wr_req, .wr_agu, .wr_data, .wr_ptr_next, .wr_ptr_valid,
      .sfr_wr_en, .sfr_wr_addr, .sfr_wr_data, .sfr_wr_lane, .reg_op_valid,
      .reg_op, .reg_old, .reg_src, .reg_result, .reg_result_valid,
      .addr_trap, .addr_trap_write);
   core_side_model i_core (.clk_sys, .sfr_rd_req, .sfr_rd_addr, .sfr_rd_data,
      .sfr_rd_hit, .psv_rd_req, .psv_rd_addr, .psv_rd_data, .sfr_wr_en,
      .sfr_wr_addr, .sfr_wr_data, .sfr_wr_lane);

   always #5 clk_sys = ~clk_sys;

   // Traffic takes about 55 cycles; 2000 means a hang
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic check(string n, logic [23:0] e, logic [23:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(addr_mode_t m, logic [15:0] a, logic b, logic pi,
                     output logic [15:0] d, output logic t);
      rd_agu = '{m, a, a, b, pi};
      rd_req = 1'b1;
      step();
      rd_req = 1'b0;
      ptr_seen = rd_ptr_next;
      step();
      `CHK("rd_valid", 1'b1, rd_valid);
      d = rd_data;
      t = addr_trap;
   endtask

   task automatic wr(addr_mode_t m, logic [15:0] a, logic b, logic [15:0] v,
                     output logic t);
      wr_agu = '{m, a, a, b, 1'b1};
      wr_data = v;
      wr_req = 1'b1;
      step();
      wr_req = 1'b0;
      `CHK("wr_ptr_valid", 1'b1, wr_ptr_valid);
      `CHK("wr_ptr", a + (b ? BYTE_STEP : WORD_STEP), wr_ptr_next);
      step();
      t = addr_trap;
   endtask

   task automatic t_program;
      pc_inc = 1'b1;
      step();
      pc_inc = 1'b0;
      `CHK("pc_inc", 24'h000002, pc);
      `CHK("pc_upper", 24'h000003, pc_upper_addr);
      pc_dec = 1'b1;
      step();
      pc_dec = 1'b0;
      `CHK("pc_dec", 24'h000000, pc);
      pc_target = 24'h001235;
      pc_load = 1'b1;
      step();
      `CHK("pc_load", 24'h001234, pc);
      `CHK("user_load", 1'b0, vector_area_load);
      pc_target = 24'h0001fe;
      step();
      pc_load = 1'b0;
      `CHK("vector_load", 1'b1, vector_area_load);
      prog_word = 24'habcdef;
      prog_word_valid = 1'b1;
      step();
      prog_word_valid = 1'b0;
      `CHK("prog_lower", 16'hcdef, prog_lower);
      `CHK("prog_upper", 16'h00ab, prog_upper);
      `CHK("prog_valid", 1'b1, prog_valid);
   endtask

   task automatic t_vectors;
      logic [6:0]  num [4] = '{7'h00, 7'h7d, 7'h00, 7'h7e};
      logic [23:0] exp [4] = '{24'h000004, 24'h0000fe, 24'h000104, 24'h0};
      vec_take = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         vec_alt = (i == 2);
         vec_num = num[i];
         step();
         `CHK("vec_valid", i != 3, vec_fetch_valid);
         if (i != 3)
            `CHK("vec_addr", exp[i], vec_fetch_addr);
      end
      vec_take = 1'b0;
   endtask

   task automatic t_reg_ops;
      logic [15:0] r [4] = '{16'h7ea5, 16'h12a5, 16'hffa5, 16'h00a5};
      reg_old = 16'h1234;
      reg_src = 16'h7ea5;
      reg_op_valid = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         reg_op = wreg_op_t'(i);
         step();
         `CHK("reg_result", r[i], reg_result);
         `CHK("reg_valid", 1'b1, reg_result_valid);
      end
      reg_op_valid = 1'b0;
   endtask

   task automatic t_data_ram;
      logic [15:0] d;
      logic        t;
      wr(AM_INDIRECT, 16'h0800, 1'b0, 16'h1234, t);
      wr(AM_INDIRECT, 16'h0801, 1'b1, 16'h0056, t);
      rd(AM_INDIRECT, 16'h0800, 1'b0, 1'b0, d, t);
      `CHK("ram_word", 16'h5634, d);
      rd(AM_DIRECT16, 16'h0801, 1'b1, 1'b0, d, t);
      `CHK("ram_hi_byte", 16'h0056, d);
      rd(AM_NEAR13, 16'h0800, 1'b1, 1'b0, d, t);
      `CHK("ram_lo_byte", 16'h0034, d);
      wr(AM_INDIRECT, 16'h47fe, 1'b0, 16'hbeef, t);
      wr(AM_INDIRECT, 16'h4800, 1'b0, 16'hdead, t);
      rd(AM_INDIRECT, 16'h47fe, 1'b0, 1'b0, d, t);
      `CHK("ram_last", 16'hbeef, d);
      rd(AM_INDIRECT, 16'h4800, 1'b0, 1'b0, d, t);
      `CHK("ram_beyond", 16'h0000, d);
   endtask

   task automatic t_sfr_psv;
      logic [15:0] d;
      logic        t;
      wr(AM_DIRECT16, 16'h0010, 1'b0, 16'hc3a5, t);
      wr(AM_INDIRECT, 16'h0010, 1'b1, 16'h005a, t);
      rd(AM_NEAR13, 16'he010, 1'b0, 1'b0, d, t);
      `CHK("sfr_word", 16'hc35a, d);
      rd(AM_INDIRECT, 16'h0700, 1'b0, 1'b0, d, t);
      `CHK("sfr_unused", 16'h0000, d);
      rd(AM_INDIRECT, 16'h8006, 1'b0, 1'b0, d, t);
      `CHK("psv_read", 16'h0006 ^ 16'h5a5a, d);
   endtask

   task automatic t_misalign;
      logic [15:0] d;
      logic        t;
      wr(AM_INDIRECT, 16'h0011, 1'b0, 16'hffff, t);
      `CHK("wr_trap", 1'b1, t);
      `CHK("wr_trap_kind", 1'b1, addr_trap_write);
      rd(AM_INDIRECT, 16'h0010, 1'b0, 1'b0, d, t);
      `CHK("wr_dropped", 16'hc35a, d);
      rd(AM_INDIRECT, 16'h0801, 1'b0, 1'b0, d, t);
      `CHK("rd_trap", 1'b1, t);
      `CHK("rd_trap_kind", 1'b0, addr_trap_write);
      `CHK("rd_odd_data", 16'h0000, d);
      step();
      `CHK("trap_pulse", 1'b0, addr_trap);
   endtask

   task automatic t_pointer;
      logic [15:0] d;
      logic        t;
      rd(AM_INDIRECT, 16'h08fe, 1'b1, 1'b1, d, t);
      `CHK("ptr_byte", 16'h08ff, ptr_seen);
      rd(AM_INDIRECT, 16'h08fe, 1'b0, 1'b1, d, t);
      `CHK("ptr_word", 16'h0900, ptr_seen);
   endtask

   initial
   begin
      clk_sys = 1'b0;
      rst = 1'b1;
      {pc_inc, pc_dec, pc_load, vec_take, vec_alt, prog_word_valid} = '0;
      {rd_req, wr_req, reg_op_valid} = '0;
      {pc_target, prog_word, vec_num, wr_data, reg_old, reg_src} = '0;
      rd_agu = '0;
      wr_agu = '0;
      reg_op = REG_WORD;
      repeat (3) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      `CHK("reset_pc", 24'h000000, pc);
      `CHK("reset_target", 24'h000002, vec_fetch_addr);
      t_program();
      t_vectors();
      t_reg_ops();
      t_data_ram();
      t_sfr_psv();
      t_misalign();
      t_pointer();
      end_of_test();
   end
endmodule // tb
